// File: rtl/pwmtor_consts.svh
// Purpose: Register offsets, field positions and reset values of the PWM timer
// Assumes: Word-aligned 32-bit register port, 8-bit byte address
// Notes:   Definitions only
`ifndef PWMTOR_CONSTS_SVH
`define PWMTOR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PWMTOR_OFF_STATUS_CTRL 8'h00
`define PWMTOR_OFF_COUNT       8'h04
`define PWMTOR_OFF_WRAP_LIMIT  8'h08
`define PWMTOR_OFF_START_VALUE 8'h0C
`define PWMTOR_OFF_SETUP       8'h10
`define PWMTOR_OFF_RELOAD_GATE 8'h14
`define PWMTOR_OFF_IRQ_STATUS  8'h18
`define PWMTOR_OFF_IRQ_MASK    8'h1C
`define PWMTOR_MATCH_BASE_HI   3'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PWMTOR_SC_FLAG_BIT     7
`define PWMTOR_SC_IEN_BIT      6
`define PWMTOR_SC_RUN_BIT      3
`define PWMTOR_PERMIT_BIT      9
`define PWMTOR_IRQ_OVF_BIT     0
`define PWMTOR_IRQ_LOAD_BIT    1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PWMTOR_RST_WRAP        16'hFFFF
`define PWMTOR_RST_START       16'h0000
`define PWMTOR_RST_MATCH       16'h0000
`define PWMTOR_LAST_CHANNEL    3'h7

`endif

// File: rtl/pwmtor_match_mem.sv
// Purpose: Buffered channel match values, eight 16-bit words
// Assumes: One write port with byte lanes, one read port
// Notes:   Read data come out of a register one cycle after rd_en
`include "pwmtor_consts.svh"
module pwmtor_match_mem (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [1:0]  wr_be,
    input  wire logic        rd_en,
    input  wire logic [2:0]  rd_addr,
    output logic      [15:0] rd_data
);
    logic [7:0][15:0] mem_reg;

    // ----------------------------------------------------------------
    // Storage and registered read
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mem_reg <= '0;
            rd_data <= `PWMTOR_RST_MATCH;
        end else begin
            if (wr_en) begin
                mem_reg[wr_addr] <= pwmtor_pkg::merge16(mem_reg[wr_addr], wr_data, wr_be);
            end
            if (rd_en) begin
                rd_data <= mem_reg[rd_addr];
            end
        end
    end
endmodule

// File: rtl/pwmtor_pkg.sv
// Purpose: Types shared by the PWM timer files
// Assumes: Constants live in pwmtor_consts.svh
// Notes:   Nothing here is imported; users write pwmtor_pkg::name
package pwmtor_pkg;

    // ----------------------------------------------------------------
    // Register port request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [3:0]  be;
        logic        wr;
        logic        rd;
    } pwmtor_req_t;

    // Channel copy engine states
    typedef enum logic [1:0] {
        PWMTOR_LD_IDLE  = 2'b00,
        PWMTOR_LD_COPY  = 2'b01,
        PWMTOR_LD_DRAIN = 2'b10
    } pwmtor_ld_t;

    // ----------------------------------------------------------------
    // State of the timer, all but the buffered match words held in pwmtor_match_mem
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0]       count;
        logic [15:0]       wrap_act;
        logic [15:0]       start_act;
        logic [15:0]       wrap_buf;
        logic [15:0]       start_buf;
        logic [7:0][15:0]  match_act;
        logic              flag;
        logic              ien;
        logic              run;
        logic              permit;
        logic              clr_armed;
        logic [4:0]        skip_cnt;
        logic [4:0]        skip_field;
        logic [1:0]        sts;
        logic [1:0]        msk;
        pwmtor_ld_t        ld_state;
        logic [2:0]        ld_idx;
        logic              ld_valid;
        logic [2:0]        ld_widx;
        logic [31:0]       rdata;
        logic              irq;
        logic [7:0]        pwm;
    } pwmtor_state_t;

    // Byte-lane merge of a 16-bit field
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

endpackage

// File: rtl/pwmtor_top.sv
// Purpose: PWM timer overflow flag, skip counting and gated buffered reloads
// Assumes: Single clock sys_clk at 25 MHz, synchronous active-high srst
// Notes:   Register port answers reads one cycle later, never stalls
`include "pwmtor_consts.svh"

// ----------------------------------------------------------------
// Module
// ----------------------------------------------------------------
module pwmtor_top (
    input  wire logic                     sys_clk,
    input  wire logic                     srst,
    input  wire pwmtor_pkg::pwmtor_req_t  req,
    output logic      [31:0]              rd_data,
    output logic                          irq,
    output logic      [7:0]               pwm_out
);
    pwmtor_pkg::pwmtor_state_t s_reg;
    pwmtor_pkg::pwmtor_state_t s_next;
    logic [15:0]               mem_rdata;
    logic                      mem_wr;
    logic                      ovf;
    logic                      load_now;

    // Decoded bus accesses
    logic                      wr_sc;
    logic                      wr_gate;
    logic                      rd_sc;

    assign rd_data = s_reg.rdata;
    assign irq     = s_reg.irq;
    assign pwm_out = s_reg.pwm;

    // ----------------------------------------------------------------
    // Decode and events
    // ----------------------------------------------------------------
    // Overflow only while counting; loads wait for the boundary
    assign ovf      = s_reg.run && (s_reg.count == s_reg.wrap_act);
    assign load_now = ovf && s_reg.permit;
    assign wr_sc    = req.wr && (req.addr == `PWMTOR_OFF_STATUS_CTRL);
    assign wr_gate  = req.wr && (req.addr == `PWMTOR_OFF_RELOAD_GATE);
    assign rd_sc    = req.rd && (req.addr == `PWMTOR_OFF_STATUS_CTRL);
    assign mem_wr   = req.wr && (req.addr[7:5] == `PWMTOR_MATCH_BASE_HI);

    // Buffered channel matches; copied out only by the load engine
    pwmtor_match_mem u_match_mem (
        .sys_clk (sys_clk),
        .srst    (srst),
        .wr_en   (mem_wr),
        .wr_addr (req.addr[4:2]),
        .wr_data (req.wdata[15:0]),
        .wr_be   (req.be[1:0]),
        .rd_en   (s_reg.ld_state == pwmtor_pkg::PWMTOR_LD_COPY),
        .rd_addr (s_reg.ld_idx),
        .rd_data (mem_rdata)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_next          = s_reg;
        s_next.ld_valid = 1'b0;

        // Counter wraps to the start value, new one if a load is due
        if (s_reg.run) begin
            if (ovf) begin
                s_next.count = load_now ? s_reg.start_buf : s_reg.start_act;
            end else begin
                s_next.count = s_reg.count + 16'h0001;
            end
        end

        // Wrap and start take their buffers only with permit set
        if (load_now) begin
            s_next.wrap_act  = s_reg.wrap_buf;
            s_next.start_act = s_reg.start_buf;
        end

        // Software side of the flag: arm on read, clear on write of zero
        if (rd_sc && s_reg.flag) begin
            s_next.clr_armed = 1'b1;
        end
        if (wr_sc && req.be[0]) begin
            s_next.ien = req.wdata[`PWMTOR_SC_IEN_BIT];
            s_next.run = req.wdata[`PWMTOR_SC_RUN_BIT];
            if (s_reg.clr_armed && !req.wdata[`PWMTOR_SC_FLAG_BIT]) begin
                s_next.flag = 1'b0;
            end
            s_next.clr_armed = 1'b0;
        end

        // Skip counting; a set in the clearing cycle wins
        // At-or-past compare, so lowering the field acts at the next overflow
        if (ovf) begin
            if (s_reg.skip_cnt >= s_reg.skip_field) begin
                s_next.flag     = 1'b1;
                s_next.skip_cnt = 5'h00;
            end else begin
                s_next.skip_cnt = s_reg.skip_cnt + 5'h01;
            end
            s_next.sts[`PWMTOR_IRQ_OVF_BIT] = 1'b1;
        end

        // Permit: software write by byte lane, hardware clear after load
        if (load_now) begin
            s_next.permit = 1'b0;
            s_next.sts[`PWMTOR_IRQ_LOAD_BIT] = 1'b1;
        end
        // Lane 1 write sets or clears; lanes 0/2/3 leave the bit alone
        if (wr_gate && req.be[1]) begin
            s_next.permit = req.wdata[`PWMTOR_PERMIT_BIT] | (s_next.permit & ~load_now);
            if (!req.wdata[`PWMTOR_PERMIT_BIT]) begin
                s_next.permit = 1'b0;
            end
        end

        // Other writable registers
        if (req.wr) begin
            unique case (req.addr)
                `PWMTOR_OFF_WRAP_LIMIT: begin
                    s_next.wrap_buf = pwmtor_pkg::merge16(s_reg.wrap_buf, req.wdata[15:0],
                                                          req.be[1:0]);
                end
                `PWMTOR_OFF_START_VALUE: begin
                    s_next.start_buf = pwmtor_pkg::merge16(s_reg.start_buf, req.wdata[15:0],
                                                           req.be[1:0]);
                end
                `PWMTOR_OFF_SETUP: begin
                    if (req.be[0]) begin
                        s_next.skip_field = req.wdata[4:0];
                    end
                end
                `PWMTOR_OFF_IRQ_STATUS: begin
                    // Write one to clear; new events this cycle survive
                    if (req.be[0]) begin
                        s_next.sts = s_next.sts & ~(req.wdata[1:0] & ~{load_now, ovf});
                    end
                end
                `PWMTOR_OFF_IRQ_MASK: begin
                    if (req.be[0]) begin
                        s_next.msk = req.wdata[1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Channel copy engine, one word per cycle behind the memory
        if (s_reg.ld_valid) begin
            s_next.match_act[s_reg.ld_widx] = mem_rdata;
        end
        unique case (s_reg.ld_state)
            pwmtor_pkg::PWMTOR_LD_IDLE: begin
                if (load_now) begin
                    s_next.ld_state = pwmtor_pkg::PWMTOR_LD_COPY;
                    s_next.ld_idx   = 3'h0;
                end
            end
            pwmtor_pkg::PWMTOR_LD_COPY: begin
                s_next.ld_valid = 1'b1;
                s_next.ld_widx  = s_reg.ld_idx;
                s_next.ld_idx   = s_reg.ld_idx + 3'h1;
                if (s_reg.ld_idx == `PWMTOR_LAST_CHANNEL) begin
                    s_next.ld_state = pwmtor_pkg::PWMTOR_LD_DRAIN;
                end
            end
            pwmtor_pkg::PWMTOR_LD_DRAIN: begin
                s_next.ld_state = pwmtor_pkg::PWMTOR_LD_IDLE;
            end
            default: begin
                s_next.ld_state = pwmtor_pkg::PWMTOR_LD_IDLE;
            end
        endcase

        // Read data, valid only the cycle after the strobe
        s_next.rdata = 32'h0000_0000;
        if (req.rd) begin
            if (req.addr[7:5] == `PWMTOR_MATCH_BASE_HI) begin
                s_next.rdata = {16'h0000, s_reg.match_act[req.addr[4:2]]};
            end else begin
                unique case (req.addr)
                    `PWMTOR_OFF_STATUS_CTRL: begin
                        s_next.rdata[`PWMTOR_SC_FLAG_BIT] = s_reg.flag;
                        s_next.rdata[`PWMTOR_SC_IEN_BIT]  = s_reg.ien;
                        s_next.rdata[`PWMTOR_SC_RUN_BIT]  = s_reg.run;
                    end
                    `PWMTOR_OFF_COUNT:       s_next.rdata[15:0] = s_reg.count;
                    `PWMTOR_OFF_WRAP_LIMIT:  s_next.rdata[15:0] = s_reg.wrap_buf;
                    `PWMTOR_OFF_START_VALUE: s_next.rdata[15:0] = s_reg.start_buf;
                    `PWMTOR_OFF_SETUP:       s_next.rdata[4:0]  = s_reg.skip_field;
                    `PWMTOR_OFF_RELOAD_GATE: s_next.rdata[`PWMTOR_PERMIT_BIT] = s_reg.permit;
                    `PWMTOR_OFF_IRQ_STATUS:  s_next.rdata[1:0]  = s_reg.sts;
                    `PWMTOR_OFF_IRQ_MASK:    s_next.rdata[1:0]  = s_reg.msk;
                    default: begin
                    end
                endcase
            end
        end

        // Interrupt tracks the flag and the masked sticky events
        s_next.irq = (s_next.flag && s_next.ien) || |(s_next.sts & s_next.msk);

        // Edge-aligned outputs: high while count is below the match
        for (int i = 0; i < 8; i++) begin
            s_next.pwm[i] = s_next.count < s_next.match_act[i];
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_reg           <= '0;
            s_reg.wrap_act  <= `PWMTOR_RST_WRAP;
            s_reg.wrap_buf  <= `PWMTOR_RST_WRAP;
            s_reg.start_act <= `PWMTOR_RST_START;
            s_reg.start_buf <= `PWMTOR_RST_START;
            s_reg.ld_state  <= pwmtor_pkg::PWMTOR_LD_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence armed_read_s;
        rd_sc && s_reg.flag;
    endsequence

    sequence zero_write_s;
        wr_sc && req.be[0] && !req.wdata[`PWMTOR_SC_FLAG_BIT] && !ovf;
    endsequence

    narrow_write_keep_a: assert property (
        (wr_gate && !req.be[1] && s_reg.permit && !ovf) |=> s_reg.permit)
        else $error("permit lost on narrow write");

    load_gated_a: assert property (
        (ovf && !s_reg.permit) |=> $stable(s_reg.wrap_act) && $stable(s_reg.start_act))
        else $error("load without permit");

    load_done_a: assert property (
        (ovf && s_reg.permit) |=> (s_reg.wrap_act == $past(s_reg.wrap_buf))
            ##[9:10] (s_reg.ld_state == pwmtor_pkg::PWMTOR_LD_IDLE))
        else $error("permitted load incomplete");

    overflow_reload_a: assert property (
        (ovf && !s_reg.permit) |=> s_reg.count == $past(s_reg.start_act))
        else $error("counter did not reload start value");

    flag_every_a: assert property (
        (ovf && s_reg.skip_field == 5'h00) |=> s_reg.flag)
        else $error("overflow did not set flag");

    clear_seq_a: assert property (
        armed_read_s ##1 zero_write_s |=> !s_reg.flag)
        else $error("flag not cleared by sequence");

    clear_gap_a: assert property (
        armed_read_s ##1 (!req.rd && !wr_sc) ##1 zero_write_s |=> !s_reg.flag)
        else $error("flag not cleared after idle cycle");

    skip_hold_a: assert property (
        (ovf && !s_reg.flag && s_reg.skip_cnt < s_reg.skip_field) |=> !s_reg.flag)
        else $error("flag set before skip count reached");

    irq_follow_a: assert property (
        (s_reg.flag && s_reg.ien) |-> irq)
        else $error("interrupt not following flag");

    irq_release_a: assert property (
        $fell(s_reg.flag) && !(|(s_reg.sts & s_reg.msk)) |-> !irq)
        else $error("interrupt held after flag cleared");
endmodule

// File: verif/pwm_timer_overflow_reload_bench.sv
// Purpose: Self-checking bench for the PWM timer overflow flag and gated reloads
// Assumes: Register map and bit positions from pwmtor_consts.svh
// Notes:   The first reload needs one full 16-bit wrap, about 65536 cycles
`include "pwmtor_consts.svh"
module pwm_timer_overflow_reload_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Signals and instance
    // ----------------------------------------------------------------
    logic                    sys_clk;
    logic                    srst;
    pwmtor_pkg::pwmtor_req_t req;
    logic [31:0]             rd_data;
    logic                    irq;
    logic [7:0]              pwm_out;
    int                      failures;
    int                      checks_done;
    int                      cyc;

    pwmtor_top u_pwmtor_top (
        .sys_clk (sys_clk),
        .srst    (srst),
        .req     (req),
        .rd_data (rd_data),
        .irq     (irq),
        .pwm_out (pwm_out)
    );

    // Clock at 25 MHz
    always #20 sys_clk = ~sys_clk;

    // Hang guard, well beyond the long first wrap
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            failures++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; lowered at the next edge, so calls never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        req.addr  <= a;
        req.wdata <= d;
        req.be    <= be;
        req.wr    <= 1'b1;
        @(posedge sys_clk);
        req.wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe; sampled mid-cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge sys_clk);
        req.rd   <= 1'b0;
        @(negedge sys_clk);
        d = rd_data;
    endtask

    task automatic wait_irq();
        for (int n = 0; n < 100; n++) begin
            @(negedge sys_clk);
            if (irq === 1'b1) break;
        end
        chk_pin({7'h00, irq}, 8'h01);
    endtask

    function automatic logic [15:0] step(input logic [15:0] x, input logic [15:0] w,
                                         input logic [15:0] s);
        step = (x == w) ? s : x + 16'h0001;
    endfunction

    // Reads come two cycles apart, so each sample is two counter steps on
    task automatic check_seq(input logic [15:0] w, input logic [15:0] s);
        logic [31:0] prev;
        logic [31:0] cur;
        rd(`PWMTOR_OFF_COUNT, prev);
        repeat (10) begin
            rd(`PWMTOR_OFF_COUNT, cur);
            chk_reg(cur, {16'h0000, step(step(prev[15:0], w, s), w, s)});
            prev = cur;
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_vals();
        logic [31:0] d;
        rd(`PWMTOR_OFF_WRAP_LIMIT, d);
        chk_reg(d, 32'h0000FFFF);
        rd(`PWMTOR_OFF_START_VALUE, d);
        chk_reg(d, 32'h00000000);
        rd(8'h20, d);
        chk_reg(d, 32'h00000000);
        rd(8'h40, d);
        chk_reg(d, 32'h00000000);
        rd(`PWMTOR_OFF_STATUS_CTRL, d);
        chk_reg(d, 32'h00000000);
    endtask

    // Buffered values only go live at an overflow with the permit set
    task automatic t_first_load();
        logic [31:0] d;
        wr(`PWMTOR_OFF_WRAP_LIMIT, 32'h00000013, 4'h3);
        wr(`PWMTOR_OFF_START_VALUE, 32'h00000003, 4'h3);
        wr(8'h20, 32'h00000006, 4'h3);
        wr(`PWMTOR_OFF_RELOAD_GATE, 32'h00000200, 4'hF);
        rd(`PWMTOR_OFF_RELOAD_GATE, d);
        chk_reg(d & 32'h00000200, 32'h00000200);
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000008, 4'hF);
        rd(8'h20, d);
        chk_reg(d, 32'h00000000);
        for (int i = 0; i < 80; i++) begin
            rd(`PWMTOR_OFF_IRQ_STATUS, d);
            if (d[`PWMTOR_IRQ_LOAD_BIT] === 1'b1) break;
            repeat (1000) @(posedge sys_clk);
        end
        chk_reg(d & 32'h00000002, 32'h00000002);
        repeat (12) @(posedge sys_clk);
        rd(`PWMTOR_OFF_RELOAD_GATE, d);
        chk_reg(d & 32'h00000200, 32'h00000000);
        rd(8'h20, d);
        chk_reg(d, 32'h00000006);
        chk_pin({7'h00, irq}, 8'h00);
        check_seq(16'h0013, 16'h0003);
    endtask

    // A narrow write without lane 1 must not lose the permit
    task automatic t_gate_narrow();
        logic [31:0] d;
        int          highs;
        wr(`PWMTOR_OFF_WRAP_LIMIT, 32'h0000000F, 4'h3);
        repeat (40) @(posedge sys_clk);
        check_seq(16'h0013, 16'h0003);
        // Counter held, so no overflow eats the permit before it is read
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000000, 4'hF);
        wr(`PWMTOR_OFF_RELOAD_GATE, 32'h00000200, 4'h3);
        wr(`PWMTOR_OFF_RELOAD_GATE, 32'h00000000, 4'h1);
        rd(`PWMTOR_OFF_RELOAD_GATE, d);
        chk_reg(d & 32'h00000200, 32'h00000200);
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000008, 4'hF);
        repeat (40) @(posedge sys_clk);
        rd(`PWMTOR_OFF_RELOAD_GATE, d);
        chk_reg(d & 32'h00000200, 32'h00000000);
        check_seq(16'h000F, 16'h0003);
        // Two whole periods of 13 hold six counts below the match of 6
        highs = 0;
        repeat (26) begin
            @(negedge sys_clk);
            if (pwm_out[0] === 1'b1) highs++;
        end
        chk_pin(8'(highs), 8'h06);
    endtask

    task automatic t_flag_clear();
        logic [31:0] d;
        int          tries;
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000040, 4'hF);
        repeat (2) @(negedge sys_clk);
        chk_pin({7'h00, irq}, 8'h01);
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000000, 4'hF);
        repeat (2) @(negedge sys_clk);
        chk_pin({7'h00, irq}, 8'h00);
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000040, 4'hF);
        repeat (2) @(negedge sys_clk);
        chk_pin({7'h00, irq}, 8'h01);
        rd(`PWMTOR_OFF_STATUS_CTRL, d);
        chk_reg(d & 32'h000000C8, 32'h000000C0);
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000040, 4'hF);
        repeat (2) @(negedge sys_clk);
        chk_pin({7'h00, irq}, 8'h00);
        // Running again: handler style clear, repeated until it sticks
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000048, 4'hF);
        wait_irq();
        tries = 0;
        do begin
            rd(`PWMTOR_OFF_STATUS_CTRL, d);
            if (d[`PWMTOR_SC_FLAG_BIT] === 1'b1) begin
                wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000048, 4'hF);
            end
            tries++;
        end while (d[`PWMTOR_SC_FLAG_BIT] !== 1'b0 && tries < 5);
        chk_reg(d & 32'h00000080, 32'h00000000);
        // Stop first, so no overflow lands between the read and the clear
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000000, 4'hF);
        rd(`PWMTOR_OFF_STATUS_CTRL, d);
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000000, 4'hF);
        rd(`PWMTOR_OFF_STATUS_CTRL, d);
        chk_reg(d & 32'h000000C8, 32'h00000000);
    endtask

    // Skip field 2: only every third overflow raises the flag
    task automatic t_skip();
        logic [31:0] d;
        wr(`PWMTOR_OFF_SETUP, 32'h00000002, 4'hF);
        wr(`PWMTOR_OFF_IRQ_MASK, 32'h00000001, 4'hF);
        wr(`PWMTOR_OFF_IRQ_STATUS, 32'h00000003, 4'hF);
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000008, 4'hF);
        for (int i = 1; i <= 3; i++) begin
            wait_irq();
            wr(`PWMTOR_OFF_IRQ_STATUS, 32'h00000001, 4'hF);
            rd(`PWMTOR_OFF_STATUS_CTRL, d);
            chk_reg(d & 32'h000000C8, (i == 3) ? 32'h00000088 : 32'h00000008);
        end
        wr(`PWMTOR_OFF_IRQ_MASK, 32'h00000000, 4'hF);
        repeat (2) @(negedge sys_clk);
        chk_pin({7'h00, irq}, 8'h00);
        // Skip zero: every overflow flags, the handler reads and clears it each time
        wr(`PWMTOR_OFF_SETUP, 32'h00000000, 4'hF);
        wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000048, 4'hF);
        repeat (3) begin
            wait_irq();
            rd(`PWMTOR_OFF_STATUS_CTRL, d);
            chk_reg(d & 32'h00000080, 32'h00000080);
            wr(`PWMTOR_OFF_STATUS_CTRL, 32'h00000048, 4'hF);
        end
    endtask

    // ----------------------------------------------------------------
    // Verdict and main sequence
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        sys_clk     = 1'b0;
        srst        = 1'b1;
        req         = '0;
        failures    = 0;
        checks_done = 0;
        cyc         = 0;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset_vals();
        t_first_load();
        t_gate_narrow();
        t_flag_clear();
        t_skip();
        wrap_up();
    end
endmodule
